// ==== src/pise_top.sv ====
`timescale 1ns/100ps
module pise_top (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire pise_pkg::pise_bus_t bus,
  output logic [15:0]             rdata,
  // phy status levels, from other clock domains
  input  wire logic               link_up,
  input  wire logic               link_good,
  input  wire logic               energy_det,
  input  wire logic               speed_10,
  input  wire logic               full_duplex,
  input  wire logic               an_complete,
  input  wire logic               mdix,
  input  wire logic               sleep_state,
  // phy event pulses, same clock
  input  wire pise_pkg::pise_evt_b_t evt_b,
  input  wire logic               false_carrier_evt,
  input  wire logic               rx_error_evt,
  output logic                    irq_pin_o,
  output logic                    irq_pin_oe
);
  localparam int NLVL = 8;

  logic [NLVL-1:0] lvl_meta_reg;
  logic [NLVL-1:0] lvl_sync_reg;
  logic [NLVL-1:0] lvl_prev_reg;
  logic [NLVL-1:0] lvl_chg;
  logic [15:0]     ise_a_reg;
  logic [15:0]     ise_b_reg;
  logic [15:0]     ctrl_reg;
  logic [7:0]      fc_cnt_reg;
  logic [7:0]      rxe_cnt_reg;
  logic [7:0]      fc_cnt_next;
  logic [7:0]      rxe_cnt_next;
  pise_pkg::pise_evt_a_t evt_a;
  logic            rd_a;
  logic            rd_b;
  logic            rd_fc;
  logic            rd_rxe;
  logic            irq_active;
  logic [7:0]      lvl_b_evt;
  logic            wr_a;
  logic            wr_b;
  logic            irq_pol;
  logic            irq_test;
  logic            irq_gen_en;

  function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic inc, input logic clr);
    logic [7:0] r;
    r = clr ? 8'h00 : v;
    if (inc && r != pise_pkg::CNT_MAX) begin
      r = r + 8'h01;
    end
    return r;
  endfunction

  // two-flop sync; only the second stage feeds the change detector
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_meta_reg <= '0;
      lvl_sync_reg <= '0;
      lvl_prev_reg <= '0;
    end else begin
      lvl_meta_reg <= {link_up, link_good, energy_det, speed_10, full_duplex,
                       an_complete, mdix, sleep_state};
      lvl_sync_reg <= lvl_meta_reg;
      lvl_prev_reg <= lvl_sync_reg;
    end
  end

  assign lvl_chg = lvl_sync_reg ^ lvl_prev_reg;
  assign lvl_b_evt = {4'h0, lvl_chg[1:0], 2'h0};

  assign rd_a   = bus.rd && bus.addr == pise_pkg::ADDR_ISE_A;
  assign rd_b   = bus.rd && bus.addr == pise_pkg::ADDR_ISE_B;
  assign rd_fc  = bus.rd && bus.addr == pise_pkg::ADDR_FC_CNT;
  assign rd_rxe = bus.rd && bus.addr == pise_pkg::ADDR_RXE_CNT;
  assign wr_a   = bus.wr && bus.addr == pise_pkg::ADDR_ISE_A;
  assign wr_b   = bus.wr && bus.addr == pise_pkg::ADDR_ISE_B;

  // counters saturate and clear on read; a count in the read cycle survives as one
  assign fc_cnt_next  = sat_inc(fc_cnt_reg, false_carrier_evt, rd_fc);
  assign rxe_cnt_next = sat_inc(rxe_cnt_reg, rx_error_evt, rd_rxe);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fc_cnt_reg  <= '0;
      rxe_cnt_reg <= '0;
    end else begin
      fc_cnt_reg  <= fc_cnt_next;
      rxe_cnt_reg <= rxe_cnt_next;
    end
  end

  always_comb begin
    evt_a.link_quality  = lvl_chg[6] && lvl_sync_reg[7];
    evt_a.energy        = lvl_chg[5];
    evt_a.link          = lvl_chg[7];
    evt_a.speed         = lvl_chg[4];
    evt_a.duplex        = lvl_chg[3];
    evt_a.an_done       = lvl_chg[2] && lvl_sync_reg[2];
    // event fires on crossing above half-full, not each count beyond it
    evt_a.false_carrier = fc_cnt_next > pise_pkg::CNT_HALF_FULL &&
                          fc_cnt_reg <= pise_pkg::CNT_HALF_FULL;
    evt_a.rx_error      = rxe_cnt_next > pise_pkg::CNT_HALF_FULL &&
                          rxe_cnt_reg <= pise_pkg::CNT_HALF_FULL;
  end

  // flags: set wins over read-clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ise_a_reg <= pise_pkg::RST_ISE;
    end else begin
      ise_a_reg[15:8] <= (rd_a ? 8'h00 : ise_a_reg[15:8]) | evt_a;
      if (wr_a) begin
        ise_a_reg[7:0] <= bus.wdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ise_b_reg <= pise_pkg::RST_ISE;
    end else begin
      ise_b_reg[15:8] <= (rd_b ? 8'h00 : ise_b_reg[15:8]) | evt_b |
                         lvl_b_evt;
      if (wr_b) begin
        ise_b_reg[7:0] <= bus.wdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= pise_pkg::RST_CTRL;
    end else if (bus.wr && bus.addr == pise_pkg::ADDR_CTRL) begin
      ctrl_reg <= {12'h000, bus.wdata[3:0]};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else if (bus.rd) begin
      unique case (bus.addr)
        pise_pkg::ADDR_CTRL:    rdata <= ctrl_reg;
        pise_pkg::ADDR_ISE_A:   rdata <= ise_a_reg;
        pise_pkg::ADDR_ISE_B:   rdata <= ise_b_reg;
        pise_pkg::ADDR_FC_CNT:  rdata <= {8'h00, fc_cnt_reg};
        pise_pkg::ADDR_RXE_CNT: rdata <= {8'h00, rxe_cnt_reg};
        default:                rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  assign irq_pol    = ctrl_reg[pise_pkg::CTRL_POL_BIT];
  assign irq_test   = ctrl_reg[pise_pkg::CTRL_TEST_BIT];
  assign irq_gen_en = ctrl_reg[pise_pkg::CTRL_IEN_BIT];

  assign irq_active = irq_test ||
                      (irq_gen_en &&
                       (|(ise_a_reg[15:8] & ise_a_reg[7:0]) ||
                        |(ise_b_reg[15:8] & ise_b_reg[7:0])));

  // pin shared with power-down input; only driven when the output enable is set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_pin_o  <= 1'b1;
      irq_pin_oe <= 1'b0;
    end else begin
      irq_pin_o  <= irq_active ^ irq_pol;
      irq_pin_oe <= ctrl_reg[pise_pkg::CTRL_OEN_BIT];
    end
  end

  a_flag_set_pend: assert property (@(posedge clk) disable iff (!arst_n)
    lvl_chg[7] |=> ise_a_reg[13])
    else $error("link change flag not set");

  a_link_qual_gate: assert property (@(posedge clk) disable iff (!arst_n)
    (lvl_chg[6] && lvl_sync_reg[7]) |=> ise_a_reg[15])
    else $error("quality flag not set");

  a_qual_down_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    (!ise_a_reg[15] && !lvl_sync_reg[7]) |=> !ise_a_reg[15])
    else $error("quality flag set with link down");

  a_energy_set: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(lvl_sync_reg[5]) |=> ise_a_reg[14])
    else $error("energy flag not set");

  a_speed_set: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(lvl_sync_reg[4]) |=> ise_a_reg[12])
    else $error("speed flag not set");

  a_duplex_set: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(lvl_sync_reg[3]) |=> ise_a_reg[11])
    else $error("duplex flag not set");

  a_an_done_set: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(lvl_sync_reg[2]) |=> ise_a_reg[10])
    else $error("negotiation done flag not set");

  a_an_fall_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    (!ise_a_reg[10] && !$rose(lvl_sync_reg[2])) |=> !ise_a_reg[10])
    else $error("negotiation done flag set without completion");

  a_mdix_set: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(lvl_sync_reg[1]) |=> ise_b_reg[11])
    else $error("crossover flag not set");

  a_sleep_lvl_set: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(lvl_sync_reg[0]) |=> ise_b_reg[10])
    else $error("sleep flag not set");

  a_half_full: assert property (@(posedge clk) disable iff (!arst_n)
    (fc_cnt_reg == pise_pkg::CNT_HALF_FULL && false_carrier_evt && !rd_fc) |=> ise_a_reg[9])
    else $error("false carrier half full flag not set");

  a_rxe_half_full: assert property (@(posedge clk) disable iff (!arst_n)
    (rxe_cnt_reg == pise_pkg::CNT_HALF_FULL && rx_error_evt && !rd_rxe) |=> ise_a_reg[8])
    else $error("receive error half full flag not set");

  a_fc_hf_once: assert property (@(posedge clk) disable iff (!arst_n)
    (fc_cnt_reg > pise_pkg::CNT_HALF_FULL && !ise_a_reg[9]) |=> !ise_a_reg[9])
    else $error("false carrier half full flag set twice");

  a_fc_saturate: assert property (@(posedge clk) disable iff (!arst_n)
    (fc_cnt_reg == pise_pkg::CNT_MAX && !rd_fc) |=> fc_cnt_reg == pise_pkg::CNT_MAX)
    else $error("false carrier counter wrapped");

  a_evt_b_sets: assert property (@(posedge clk) disable iff (!arst_n)
    evt_b.jabber |=> ise_b_reg[8])
    else $error("jabber flag not set");

  a_eee_set: assert property (@(posedge clk) disable iff (!arst_n)
    evt_b.eee_err |=> ise_b_reg[15])
    else $error("eee error flag not set");

  a_an_err_set: assert property (@(posedge clk) disable iff (!arst_n)
    evt_b.an_err |=> ise_b_reg[14])
    else $error("negotiation error flag not set");

  a_page_set: assert property (@(posedge clk) disable iff (!arst_n)
    evt_b.page_rx |=> ise_b_reg[13])
    else $error("page flag not set");

  a_fifo_set: assert property (@(posedge clk) disable iff (!arst_n)
    evt_b.loop_fifo_overrun_underrun |=> ise_b_reg[12])
    else $error("loop fifo flag not set");

  a_pol_wake_set: assert property (@(posedge clk) disable iff (!arst_n)
    evt_b.pol_or_wake |=> ise_b_reg[9])
    else $error("polarity or wake flag not set");

  a_qual_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_a_reg[15] && !rd_a) |=> ise_a_reg[15])
    else $error("quality flag lost");

  a_energy_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_a_reg[14] && !rd_a) |=> ise_a_reg[14])
    else $error("energy flag lost");

  a_link_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_a_reg[13] && !rd_a) |=> ise_a_reg[13])
    else $error("link flag lost");

  a_speed_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_a_reg[12] && !rd_a) |=> ise_a_reg[12])
    else $error("speed flag lost");

  a_duplex_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_a_reg[11] && !rd_a) |=> ise_a_reg[11])
    else $error("duplex flag lost");

  a_an_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_a_reg[10] && !rd_a) |=> ise_a_reg[10])
    else $error("negotiation done flag lost");

  a_fc_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_a_reg[9] && !rd_a) |=> ise_a_reg[9])
    else $error("false carrier flag lost");

  a_rxe_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_a_reg[8] && !rd_a) |=> ise_a_reg[8])
    else $error("receive error flag lost");

  a_eee_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_b_reg[15] && !rd_b) |=> ise_b_reg[15])
    else $error("eee error flag lost");

  a_an_err_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_b_reg[14] && !rd_b) |=> ise_b_reg[14])
    else $error("negotiation error flag lost");

  a_page_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_b_reg[13] && !rd_b) |=> ise_b_reg[13])
    else $error("page flag lost");

  a_fifo_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_b_reg[12] && !rd_b) |=> ise_b_reg[12])
    else $error("loop fifo flag lost");

  a_mdix_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_b_reg[11] && !rd_b) |=> ise_b_reg[11])
    else $error("crossover flag lost");

  a_flag_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_b_reg[10] && !rd_b) |=> ise_b_reg[10])
    else $error("sleep flag lost");

  a_pol_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_b_reg[9] && !rd_b) |=> ise_b_reg[9])
    else $error("polarity or wake flag lost");

  a_jabber_holds: assert property (@(posedge clk) disable iff (!arst_n)
    (ise_b_reg[8] && !rd_b) |=> ise_b_reg[8])
    else $error("jabber flag lost");

  a_read_clears_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_a && evt_a == 8'h00) |=> ise_a_reg[15:8] == 8'h00)
    else $error("read did not clear flags of reg a");

  a_read_clears_b: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_b && evt_b == 8'h00 && lvl_chg[1:0] == 2'h0) |=> ise_b_reg[15:8] == 8'h00)
    else $error("read did not clear flags of reg b");

  a_qual_rd_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_a && !($changed(lvl_sync_reg[6]) && lvl_sync_reg[7])) |=> !ise_a_reg[15])
    else $error("read did not clear quality flag");

  a_energy_rd_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_a && !$changed(lvl_sync_reg[5])) |=> !ise_a_reg[14])
    else $error("read did not clear energy flag");

  a_speed_rd_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_a && !$changed(lvl_sync_reg[4])) |=> !ise_a_reg[12])
    else $error("read did not clear speed flag");

  a_duplex_rd_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_a && !$changed(lvl_sync_reg[3])) |=> !ise_a_reg[11])
    else $error("read did not clear duplex flag");

  a_an_rd_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_a && !$rose(lvl_sync_reg[2])) |=> !ise_a_reg[10])
    else $error("read did not clear negotiation done flag");

  a_enable_rst: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(ise_a_reg[7:0]) |-> $past(wr_a))
    else $error("enables of reg a changed without a write");

  a_enable_b_rst: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(ise_b_reg[7:0]) |-> $past(wr_b))
    else $error("enables of reg b changed without a write");

  a_enable_a_wr: assert property (@(posedge clk) disable iff (!arst_n)
    wr_a |=> {8'h00, ise_a_reg[7:0]} == ($past(bus.wdata) & 16'h00ff))
    else $error("write did not land in enables of reg a");

  a_enable_b_wr: assert property (@(posedge clk) disable iff (!arst_n)
    wr_b |=> {8'h00, ise_b_reg[7:0]} == ($past(bus.wdata) & 16'h00ff))
    else $error("write did not land in enables of reg b");

  a_test_irq: assert property (@(posedge clk) disable iff (!arst_n)
    irq_test |=> irq_pin_o != $past(irq_pol))
    else $error("test bit gives no interrupt");

  a_global_gate: assert property (@(posedge clk) disable iff (!arst_n)
    (!irq_gen_en && !irq_test) |=> irq_pin_o == $past(irq_pol))
    else $error("interrupt passed with global enable off");

  a_irq_active: assert property (@(posedge clk) disable iff (!arst_n)
    (irq_gen_en && |(ise_a_reg[15:8] & ise_a_reg[7:0])) |=> irq_pin_o != $past(irq_pol))
    else $error("enabled pending flag gives no interrupt");

  a_irq_idle: assert property (@(posedge clk) disable iff (!arst_n)
    (!irq_test && (ise_a_reg[15:8] & ise_a_reg[7:0]) == 8'h00 &&
     (ise_b_reg[15:8] & ise_b_reg[7:0]) == 8'h00) |=> irq_pin_o == $past(irq_pol))
    else $error("interrupt without enabled pending flag");

  a_rdata_a: assert property (@(posedge clk) disable iff (!arst_n)
    rd_a |=> rdata == $past(ise_a_reg))
    else $error("read data of reg a wrong");
endmodule

// ==== src/pise_pkg.sv ====
// What this block does
// - reg a bit 15 sets on link quality change while link up; read clears
// - reg a bit 14 sets on energy detect change; read clears
// - reg a bit 13 sets on link status change; pending until read
// - reg a bit 12 sets on speed status change; pending until read
// - reg a bit 11 sets on duplex status change; read clears
// - reg a bit 10 sets on auto-negotiation complete; pending until read
// - reg a bit 9 sets when false carrier counter exceeds half-full; read clears
// - reg a bit 8 sets when receive error counter exceeds half-full; read clears
// - reg a bits 7..0 are read-write enables for flags eight above, reset zero
// - reg b bit 15 sets on energy-efficient-ethernet error; read clears
// - reg b bit 14 sets on auto-negotiation error; pending until read
// - reg b bit 13 sets on received negotiation page; read clears
// - reg b bit 12 sets on loopback fifo overflow or underflow; read clears
// - reg b bit 11 sets on crossover status change; read clears
// - reg b bit 10 sets on sleep mode event; pending until read
// - reg b bit 9 sets on inverted polarity or wake packet; read clears
// - reg b bit 8 sets on jabber detect; read clears
// - reg b bits 7..0 are read-write enables for flags eight above, reset zero
// - event interrupts reach output only with global interrupt enable set
// - polarity one: output idles high, low on interrupt; zero inverts
// - test interrupt bit forces an interrupt while set
// - counters raise half-full event when count exceeds 7fh
package pise_pkg;
  localparam logic [4:0]  ADDR_CTRL      = 5'h11;
  localparam logic [4:0]  ADDR_ISE_A     = 5'h12;
  localparam logic [4:0]  ADDR_ISE_B     = 5'h13;
  localparam logic [4:0]  ADDR_FC_CNT    = 5'h14;
  localparam logic [4:0]  ADDR_RXE_CNT   = 5'h15;
  localparam logic [15:0] RST_ISE        = 16'h0000;
  localparam logic [15:0] RST_CTRL       = 16'h0008;
  localparam int          CTRL_POL_BIT   = 3;
  localparam int          CTRL_TEST_BIT  = 2;
  localparam int          CTRL_IEN_BIT   = 1;
  localparam int          CTRL_OEN_BIT   = 0;
  localparam logic [7:0]  CNT_HALF_FULL  = 8'h7f;
  localparam logic [7:0]  CNT_MAX        = 8'hff;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pise_bus_t;

  // events of reg a, bit order 7..0 maps to flag 15..8
  typedef struct packed {
    logic link_quality;
    logic energy;
    logic link;
    logic speed;
    logic duplex;
    logic an_done;
    logic false_carrier;
    logic rx_error;
  } pise_evt_a_t;

  typedef struct packed {
    logic eee_err;
    logic an_err;
    logic page_rx;
    logic loop_fifo_overrun_underrun;
    logic crossover;
    logic sleep;
    logic pol_or_wake;
    logic jabber;
  } pise_evt_b_t;
endpackage

// ==== test/pise_top_tb_top.sv ====
`timescale 1ns/100ps
module pise_top_tb_top;
  logic                  clk = 1'b0;
  logic                  arst_n = 1'b0;
  pise_pkg::pise_bus_t   bus = '0;
  logic [15:0]           rdata;
  logic [7:0]            lv = 8'h00;
  pise_pkg::pise_evt_b_t evt_b = '0;
  logic                  fc_evt = 1'b0;
  logic                  rxe_evt = 1'b0;
  logic                  irq_o;
  logic                  irq_oe;
  int                    num_errors = 0;
  int                    checks = 0;
  localparam logic [4:0] RA = pise_pkg::ADDR_ISE_A;
  localparam logic [4:0] RB = pise_pkg::ADDR_ISE_B;
  localparam logic [4:0] RC = pise_pkg::ADDR_CTRL;

  always #5 clk = ~clk;

  // lv: link_up, link_good, energy, speed, duplex, an_complete, mdix, sleep
  pise_top u_pise_top (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
    .link_up(lv[0]), .link_good(lv[1]), .energy_det(lv[2]), .speed_10(lv[3]),
    .full_duplex(lv[4]), .an_complete(lv[5]), .mdix(lv[6]), .sleep_state(lv[7]),
    .evt_b(evt_b), .false_carrier_evt(fc_evt), .rx_error_evt(rxe_evt),
    .irq_pin_o(irq_o), .irq_pin_oe(irq_oe));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the read edge
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask

  task automatic toggle(input int i);
    @(posedge clk);
    lv[i] <= ~lv[i];
    repeat (6) @(posedge clk);
  endtask

  // second read proves the flag was cleared by the first
  task automatic lvl(input int i, input logic [4:0] a, input logic [15:0] exp);
    toggle(i);
    rd(a, exp);
    rd(a, 16'h0000);
  endtask

  task automatic pulse_cnt(input bit rx, input int n);
    repeat (n) begin
      @(posedge clk);
      if (rx) rxe_evt <= 1'b1;
      else fc_evt <= 1'b1;
    end
    @(posedge clk);
    rxe_evt <= 1'b0;
    fc_evt <= 1'b0;
  endtask

  task automatic t_reset;
    rd(RA, 16'h0000);
    rd(RB, 16'h0000);
    rd(RC, pise_pkg::RST_CTRL);
    check({15'h0000, irq_o}, 16'h0001);
    check({15'h0000, irq_oe}, 16'h0000);
  endtask

  task automatic t_enables;
    wr(RA, 16'hffff);
    rd(RA, 16'h00ff);
    wr(RB, 16'hff5a);
    rd(RB, 16'h005a);
    wr(RA, 16'h0000);
    wr(RB, 16'h0000);
    rd(5'h1f, 16'h0000);
  endtask

  task automatic t_levels;
    lvl(0, RA, 16'h2000);
    lvl(1, RA, 16'h8000);
    lvl(2, RA, 16'h4000);
    lvl(3, RA, 16'h1000);
    lvl(4, RA, 16'h0800);
    lvl(5, RA, 16'h0400);
    lvl(5, RA, 16'h0000);
    lvl(6, RB, 16'h0800);
    lvl(7, RB, 16'h0400);
    lvl(0, RA, 16'h2000);
    lvl(1, RA, 16'h0000);
  endtask

  task automatic t_pulses;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      evt_b <= pise_pkg::pise_evt_b_t'(8'h01 << i);
      @(posedge clk);
      evt_b <= '0;
      rd(RB, 16'h0100 << i);
      rd(RB, 16'h0000);
    end
  endtask

  task automatic t_counters;
    for (int rx = 0; rx < 2; rx++) begin
      pulse_cnt(rx[0], 127);
      rd(RA, 16'h0000);
      pulse_cnt(rx[0], 1);
      rd(RA, rx ? 16'h0100 : 16'h0200);
      rd(rx ? pise_pkg::ADDR_RXE_CNT : pise_pkg::ADDR_FC_CNT, 16'h0080);
    end
  endtask

  task automatic t_irq;
    wr(RC, 16'h000b);
    wr(RA, 16'h0020);
    toggle(0);
    #1;
    check({15'h0000, irq_o}, 16'h0000);
    check({15'h0000, irq_oe}, 16'h0001);
    rd(RA, 16'h2020);
    repeat (3) @(posedge clk);
    #1;
    check({15'h0000, irq_o}, 16'h0001);
    wr(RC, 16'h0009);
    toggle(0);
    #1;
    check({15'h0000, irq_o}, 16'h0001);
    rd(RA, 16'h2020);
    wr(RC, 16'h0005);
    repeat (3) @(posedge clk);
    #1;
    check({15'h0000, irq_o}, 16'h0001);
    wr(RC, 16'h0001);
    repeat (3) @(posedge clk);
    #1;
    check({15'h0000, irq_o}, 16'h0000);
  endtask

  task automatic final_report;
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_enables();
    t_levels();
    t_pulses();
    t_counters();
    t_irq();
    final_report();
  end
endmodule
